// file: logic/anno_pkg.sv
package anno_pkg;

  // Display ownership states, one-hot
  typedef enum logic [2:0] {
    SHOW_IDLE  = 3'b001,
    SHOW_CODE  = 3'b010,
    SHOW_BLANK = 3'b100
  } show_state_e;

  typedef logic [7:0] code_t;

endpackage

// file: logic/anno_regs.svh
`ifndef ANNO_REGS_SVH
`define ANNO_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CFG        8'h00
`define OFS_INPUT_VOLT 8'h04
`define OFS_UV_LEVEL   8'h08
`define OFS_DI_FUNC_LO 8'h0C
`define OFS_DI_FUNC_HI 8'h10
`define OFS_BUS_VOLT   8'h14
`define OFS_STATUS     8'h18

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define RST_CFG        1'h0
`define RST_INPUT_VOLT 16'h01CC
`define RST_UV_LEVEL   16'h0000
`define RST_DI_FUNC    32'h0000_0000
`define CFG_HV_BIT     0
`define ST_CODE_LSB    8

// ----------------------------------------
// Bus voltage thresholds and input voltage limit, volts
// ----------------------------------------
`define OV_LV          16'h019A
`define OV_HV          16'h0334
`define OV_HV_REDUCED  16'h02BC
`define IN_VOLT_LIMIT  16'h01CC
`define UV_LV          16'h00BE
`define UV_HV          16'h017C

// ----------------------------------------
// Input function codes
// ----------------------------------------
`define FUNC_OVERHEAT  8'h20
`define FUNC_NONE      8'h00
`define FUNC_MAX       8'h3F

// ----------------------------------------
// Display codes
// ----------------------------------------
`define CODE_NONE      8'h00
`define CODE_OV        8'h01
`define CODE_UV        8'h02
`define CODE_OH        8'h03
`define CODE_DIAG_DUP  8'h10
`define CODE_DIAG_FUNC 8'h11
`define CODE_DIAG_UV   8'h12

// ----------------------------------------
// Timing, in milliseconds and clock rate
// ----------------------------------------
`define CLK_KHZ        125000
`define REDISP_MS      5000
`define FLASH_HALF_MS  500

`endif

// file: logic/anno_timer.sv
`timescale 1ns/10ps
`include "anno_regs.svh"

module anno_timer #(
  parameter int unsigned TICK_CYC = `CLK_KHZ,
  parameter int unsigned REDISP_MS = `REDISP_MS,
  parameter int unsigned FLASH_MS = `FLASH_HALF_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control side
  anno_timer_if.tmr t
);

  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic tick;
  logic next_tick;
  logic [31:0] blank_cnt;
  logic [31:0] next_blank_cnt;
  logic blanking;
  logic next_blanking;
  logic [31:0] flash_cnt;
  logic [31:0] next_flash_cnt;
  logic flash_on;
  logic next_flash_on;

  assign t.blanking = blanking;
  assign t.flash_on = flash_on;

  // Millisecond enable pulse from the one clock
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'h0000_0001;
    if (tick_cnt >= TICK_CYC - 1) begin
      next_tick_cnt = 32'h0000_0000;
      next_tick = 1'b1;
    end
  end

  // Re-display hold; a new key press restarts the full wait
  always_comb begin
    next_blanking = blanking;
    next_blank_cnt = blank_cnt;
    if (t.blank_req) begin
      next_blanking = 1'b1;
      next_blank_cnt = REDISP_MS;
    end else if (blanking && tick) begin
      if (blank_cnt <= 32'h0000_0001) begin
        next_blanking = 1'b0;
        next_blank_cnt = 32'h0000_0000;
      end else begin
        next_blank_cnt = blank_cnt - 32'h0000_0001;
      end
    end
  end

  // Flash cadence, free running so all codes blink in step
  always_comb begin
    next_flash_on = flash_on;
    next_flash_cnt = flash_cnt;
    if (tick) begin
      if (flash_cnt >= FLASH_MS - 1) begin
        next_flash_cnt = 32'h0000_0000;
        next_flash_on = ~flash_on;
      end else begin
        next_flash_cnt = flash_cnt + 32'h0000_0001;
      end
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
      blank_cnt <= 32'h0000_0000;
      blanking <= 1'b0;
      flash_cnt <= 32'h0000_0000;
      flash_on <= 1'b1;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      blank_cnt <= next_blank_cnt;
      blanking <= next_blanking;
      flash_cnt <= next_flash_cnt;
      flash_on <= next_flash_on;
    end
  end

endmodule

// file: logic/anno_timer_if.sv
`timescale 1ns/10ps

interface anno_timer_if;
  logic blank_req;
  logic blanking;
  logic flash_on;

  modport ctl (output blank_req, input blanking, input flash_on);
  modport tmr (input blank_req, output blanking, output flash_on);
endinterface

// file: logic/warning_self_diag_annunciator.sv
`timescale 1ns/10ps
`include "anno_regs.svh"

module warning_self_diag_annunciator #(
  parameter int unsigned TICK_CYC = `CLK_KHZ,
  parameter int unsigned REDISP_MS = `REDISP_MS,
  parameter int unsigned FLASH_MS = `FLASH_HALF_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive state
  input wire logic [15:0] bus_voltage,
  input wire logic precharge_on,
  input wire logic drive_running,
  input wire logic [7:0] multifunction_inputs,
  input wire logic fault_trip,
  // Operator keypad
  input wire logic reset_key,
  output logic disp_own,
  output logic disp_lit,
  output logic [7:0] disp_code,
  // Run and relay
  input wire logic run_cmd,
  output logic run_accept,
  output logic fault_relay,
  // Warning levels
  output logic bus_overvolt_warning,
  output logic bus_undervolt_warning,
  output logic drive_overheat_warning,
  output logic diag_error
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic hv_class;
  logic next_hv_class;
  logic [15:0] input_volt;
  logic [15:0] next_input_volt;
  logic [15:0] uv_level;
  logic [15:0] next_uv_level;
  logic [31:0] di_func_lo;
  logic [31:0] next_di_func_lo;
  logic [31:0] di_func_hi;
  logic [31:0] next_di_func_hi;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_en;
  logic mapped;
  logic [31:0] status_word;

  assign wr_en = psel && penable && pready && pwrite;

  // Address decode; unmapped offsets answer with an error
  always_comb begin
    mapped = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_CFG: next_prdata = {31'h0000_0000, hv_class};
      `OFS_INPUT_VOLT: next_prdata = {16'h0000, input_volt};
      `OFS_UV_LEVEL: next_prdata = {16'h0000, uv_level};
      `OFS_DI_FUNC_LO: next_prdata = di_func_lo;
      `OFS_DI_FUNC_HI: next_prdata = di_func_hi;
      `OFS_BUS_VOLT: next_prdata = {16'h0000, bus_voltage};
      `OFS_STATUS: next_prdata = status_word;
      default: mapped = 1'b0;
    endcase
    if (!(psel && !penable) || pwrite) begin
      next_prdata = prdata;
    end
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
  end

  // Register writes take effect only at the completing edge
  always_comb begin
    next_hv_class = hv_class;
    next_input_volt = input_volt;
    next_uv_level = uv_level;
    next_di_func_lo = di_func_lo;
    next_di_func_hi = di_func_hi;
    if (wr_en) begin
      case (paddr)
        `OFS_CFG: next_hv_class = pwdata[`CFG_HV_BIT];
        `OFS_INPUT_VOLT: next_input_volt = pwdata[15:0];
        `OFS_UV_LEVEL: next_uv_level = pwdata[15:0];
        `OFS_DI_FUNC_LO: next_di_func_lo = pwdata;
        `OFS_DI_FUNC_HI: next_di_func_hi = pwdata;
        default: next_hv_class = hv_class;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hv_class <= `RST_CFG;
      input_volt <= `RST_INPUT_VOLT;
      uv_level <= `RST_UV_LEVEL;
      di_func_lo <= `RST_DI_FUNC;
      di_func_hi <= `RST_DI_FUNC;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      hv_class <= next_hv_class;
      input_volt <= next_input_volt;
      uv_level <= next_uv_level;
      di_func_lo <= next_di_func_lo;
      di_func_hi <= next_di_func_hi;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------
  // Condition detection
  // ----------------------------------------
  logic [15:0] ov_thresh;
  logic [15:0] uv_thresh;
  logic [63:0] func_all;
  logic ov_now;
  logic uv_now;
  logic oh_now;
  logic dup_err;
  logic func_err;
  logic uv_err;
  logic diag_now;
  anno_pkg::code_t code_now;

  assign func_all = {di_func_hi, di_func_lo};

  // Thresholds follow class and input voltage setting
  always_comb begin
    if (!hv_class) begin
      ov_thresh = `OV_LV;
    end else if (input_volt < `IN_VOLT_LIMIT) begin
      ov_thresh = `OV_HV_REDUCED;
    end else begin
      ov_thresh = `OV_HV;
    end
    // Zero level means the class default applies
    if (uv_level != `RST_UV_LEVEL) begin
      uv_thresh = uv_level;
    end else begin
      uv_thresh = hv_class ? `UV_HV : `UV_LV;
    end
  end

  // All checks are plain levels, re-evaluated each cycle
  always_comb begin
    ov_now = bus_voltage > ov_thresh;
    uv_now = (bus_voltage < uv_thresh) ||
             (drive_running && !precharge_on);
    oh_now = 1'b0;
    dup_err = 1'b0;
    func_err = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (func_all[i*8 +: 8] == `FUNC_OVERHEAT &&
          multifunction_inputs[i]) begin
        oh_now = 1'b1;
      end
      if (func_all[i*8 +: 8] > `FUNC_MAX) begin
        func_err = 1'b1;
      end
      for (int j = i + 1; j < 8; j++) begin
        if (func_all[i*8 +: 8] != `FUNC_NONE &&
            func_all[i*8 +: 8] == func_all[j*8 +: 8]) begin
          dup_err = 1'b1;
        end
      end
    end
    // A trip level at or above the high limit is contradictory
    uv_err = uv_thresh >= ov_thresh;
    diag_now = dup_err || func_err || uv_err;
  end

  // Fixed priority: diagnostics, then over, under, heat
  always_comb begin
    if (dup_err) begin
      code_now = `CODE_DIAG_DUP;
    end else if (func_err) begin
      code_now = `CODE_DIAG_FUNC;
    end else if (uv_err) begin
      code_now = `CODE_DIAG_UV;
    end else if (ov_now) begin
      code_now = `CODE_OV;
    end else if (uv_now) begin
      code_now = `CODE_UV;
    end else if (oh_now) begin
      code_now = `CODE_OH;
    end else begin
      code_now = `CODE_NONE;
    end
  end

  // ----------------------------------------
  // Keypad display ownership
  // ----------------------------------------
  anno_timer_if tif ();
  anno_pkg::show_state_e show;
  anno_pkg::show_state_e next_show;
  logic key_prev;
  logic next_key_prev;
  logic key_press;
  logic any_now;
  logic blank_req;

  assign key_press = reset_key && !key_prev;
  assign any_now = code_now != `CODE_NONE;
  assign tif.blank_req = blank_req;

  anno_timer #(
    .TICK_CYC(TICK_CYC),
    .REDISP_MS(REDISP_MS),
    .FLASH_MS(FLASH_MS)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .t(tif.tmr)
  );

  always_comb begin
    next_show = show;
    next_key_prev = reset_key;
    blank_req = 1'b0;
    case (show)
      anno_pkg::SHOW_IDLE: begin
        if (any_now) begin
          next_show = anno_pkg::SHOW_CODE;
        end
      end
      anno_pkg::SHOW_CODE: begin
        if (!any_now) begin
          next_show = anno_pkg::SHOW_IDLE;
        end else if (key_press) begin
          next_show = anno_pkg::SHOW_BLANK;
          blank_req = 1'b1;
        end
      end
      anno_pkg::SHOW_BLANK: begin
        if (key_press) begin
          blank_req = 1'b1;
        end else if (!tif.blanking) begin
          // Code returns only if the condition still stands
          next_show = any_now ? anno_pkg::SHOW_CODE
                              : anno_pkg::SHOW_IDLE;
        end
      end
      default: next_show = anno_pkg::SHOW_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      show <= anno_pkg::SHOW_IDLE;
      key_prev <= 1'b0;
    end else begin
      show <= next_show;
      key_prev <= next_key_prev;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic next_disp_own;
  logic next_disp_lit;
  anno_pkg::code_t next_disp_code;
  logic next_run_accept;
  logic next_fault_relay;

  // Keypad keeps its own content unless a code is shown
  always_comb begin
    next_disp_own = show == anno_pkg::SHOW_CODE && any_now;
    next_disp_lit = next_disp_own && tif.flash_on;
    next_disp_code = next_disp_own ? code_now : `CODE_NONE;
    // Warnings never gate the run path, diagnostics do
    next_run_accept = run_cmd && !diag_now;
    // Relay follows true faults only
    next_fault_relay = fault_trip;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      disp_own <= 1'b0;
      disp_lit <= 1'b0;
      disp_code <= `CODE_NONE;
      run_accept <= 1'b0;
      fault_relay <= 1'b0;
      bus_overvolt_warning <= 1'b0;
      bus_undervolt_warning <= 1'b0;
      drive_overheat_warning <= 1'b0;
      diag_error <= 1'b0;
    end else begin
      disp_own <= next_disp_own;
      disp_lit <= next_disp_lit;
      disp_code <= next_disp_code;
      run_accept <= next_run_accept;
      fault_relay <= next_fault_relay;
      bus_overvolt_warning <= ov_now;
      bus_undervolt_warning <= uv_now;
      drive_overheat_warning <= oh_now;
      diag_error <= diag_now;
    end
  end

  // Status word: warning levels, diagnostics, shown code
  assign status_word = {16'h0000, disp_code, 1'b0, uv_err, func_err,
                        dup_err, diag_error, drive_overheat_warning,
                        bus_undervolt_warning, bus_overvolt_warning};

endmodule

// file: sim/anno_monitor.sv
`timescale 1ns/10ps
module anno_monitor #(
  parameter int unsigned FLASH_CYC = 62500000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Inputs
  input wire logic reset_key,
  input wire logic fault_trip,
  input wire logic run_cmd,
  input wire logic drive_running,
  input wire logic precharge_on,
  input wire logic [15:0] bus_voltage,
  // Outputs
  input wire logic disp_own,
  input wire logic disp_lit,
  input wire logic run_accept,
  input wire logic fault_relay,
  input wire logic bus_overvolt_warning,
  input wire logic bus_undervolt_warning,
  input wire logic drive_overheat_warning,
  input wire logic diag_error
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic any_warn;
  logic [5:0] quiet;
  logic [5:0] next_quiet;
  logic lit_prev;
  logic [31:0] lit_run;
  logic [31:0] next_lit_run;
  // Cycles since the key, saturating so old presses look alike
  assign any_warn = bus_overvolt_warning | bus_undervolt_warning |
    drive_overheat_warning | diag_error;
  always_comb begin
    next_quiet = quiet;
    if (reset_key)
      next_quiet = 6'h00;
    else if (quiet != 6'h3F)
      next_quiet = quiet + 6'h01;
    // Cycles the shown code has kept one flash phase
    next_lit_run = lit_run + 32'h0000_0001;
    if (!disp_own || disp_lit != lit_prev)
      next_lit_run = 32'h0000_0000;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      quiet <= 6'h3F;
      lit_prev <= 1'b0;
      lit_run <= 32'h0000_0000;
    end else begin
      quiet <= next_quiet;
      lit_prev <= disp_lit;
      lit_run <= next_lit_run;
    end
  end
  // Reset cycle skipped: outputs still hold reset values there
  a_relay_follows_trip: assert property (
    !$past(rst) |-> fault_relay == $past(fault_trip))
    else $error("Relay not a copy of trip");
  a_run_gated: assert property (
    !$past(rst) |-> run_accept == ($past(run_cmd) && !diag_error))
    else $error("Run accept wrong");
  a_overvolt_max: assert property (
    !$past(rst) && $past(bus_voltage) > 16'h0334 |-> bus_overvolt_warning)
    else $error("Missed overvoltage");
  a_precharge_low: assert property (
    !$past(rst) && $past(drive_running && !precharge_on)
    |-> bus_undervolt_warning)
    else $error("Missed precharge undervoltage");
  a_code_shown: assert property (
    any_warn && quiet == 6'h3F ##1 any_warn |-> disp_own)
    else $error("Code not shown");
  a_lit_in_view: assert property (
    disp_lit |-> disp_own)
    else $error("Lit without shown code");
  a_lit_flashes: assert property (
    lit_run <= FLASH_CYC)
    else $error("Shown code not flashing");
  a_view_restored: assert property (
    !any_warn |=> !disp_own)
    else $error("View not restored");
  a_key_blanks: assert property (
    $rose(reset_key) && any_warn && disp_own |-> ##2 (!disp_own) [*8])
    else $error("Key did not blank");
  a_code_returns: assert property (
    $rose(reset_key) && disp_own |-> ##[12:40] (disp_own || !any_warn))
    else $error("Code did not return");
  c_blank: cover property ($rose(reset_key) && disp_own);
  c_diag: cover property (diag_error && run_cmd);
  c_heat: cover property (drive_overheat_warning ##2 disp_own);
endmodule

bind warning_self_diag_annunciator anno_monitor
  #(.FLASH_CYC(FLASH_MS * TICK_CYC)) mon (
  .ref_clk(ref_clk), .rst(rst), .reset_key(reset_key),
  .fault_trip(fault_trip), .run_cmd(run_cmd),
  .drive_running(drive_running), .precharge_on(precharge_on),
  .bus_voltage(bus_voltage), .disp_own(disp_own), .disp_lit(disp_lit),
  .run_accept(run_accept), .fault_relay(fault_relay),
  .bus_overvolt_warning(bus_overvolt_warning),
  .bus_undervolt_warning(bus_undervolt_warning),
  .drive_overheat_warning(drive_overheat_warning),
  .diag_error(diag_error));

// file: sim/anno_panel.sv
`timescale 1ns/10ps
module anno_panel (
  // Clock
  input wire logic ref_clk,
  // Bench side
  input wire logic press,
  input wire logic [7:0] levels,
  // Drive side
  output logic reset_key,
  output logic [7:0] multifunction_inputs
);
  logic [1:0] hold = 2'h0;
  // A finger holds the key three cycles, not one
  always @(posedge ref_clk) begin
    if (press)
      hold <= 2'h3;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
  end
  assign reset_key = hold != 2'h0;
  // Terminal levels wired straight through
  assign multifunction_inputs = levels;
endmodule

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] bus_voltage = 16'h012C;
  logic precharge_on = 1'b1;
  logic drive_running = 1'b0;
  logic fault_trip = 1'b0;
  logic run_cmd = 1'b0;
  logic press = 1'b0;
  logic [7:0] levels = 8'h00;
  logic [31:0] prdata;
  logic [31:0] fn;
  logic pready, pslverr, reset_key, run_accept;
  logic [7:0] mfi;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 5388;
  localparam logic [31:0] all_m = 32'hFFFF_FFFF;
  localparam logic [31:0] st_m = 32'h0000_FF7F;
  // Class, input volts, low level, bus volts, code and flags
  logic [15:0] tv [11][5] = '{
    '{16'h0, 16'h1CC, 16'h0, 16'h19A, 16'h0000},
    '{16'h0, 16'h1CC, 16'h0, 16'h19B, 16'h0101},
    '{16'h0, 16'h1CC, 16'h0, 16'h0BD, 16'h0202},
    '{16'h0, 16'h1CC, 16'h0, 16'h0BE, 16'h0000},
    '{16'h1, 16'h1CC, 16'h0, 16'h334, 16'h0000},
    '{16'h1, 16'h1CC, 16'h0, 16'h335, 16'h0101},
    '{16'h1, 16'h1CC, 16'h0, 16'h17B, 16'h0202},
    '{16'h1, 16'h1CB, 16'h0, 16'h2BD, 16'h0101},
    '{16'h1, 16'h1CB, 16'h0, 16'h2BC, 16'h0000},
    '{16'h0, 16'h1CC, 16'h0FA, 16'h0F9, 16'h0202},
    '{16'h1, 16'h1CC, 16'h33E, 16'h1F4, 16'h124A}};

  warning_self_diag_annunciator #(.TICK_CYC(4), .REDISP_MS(5), .FLASH_MS(2))
  dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_voltage(bus_voltage),
    .precharge_on(precharge_on), .drive_running(drive_running),
    .multifunction_inputs(mfi), .fault_trip(fault_trip),
    .reset_key(reset_key), .disp_own(), .disp_lit(), .disp_code(),
    .run_cmd(run_cmd), .run_accept(run_accept), .fault_relay(),
    .bus_overvolt_warning(), .bus_undervolt_warning(),
    .drive_overheat_warning(), .diag_error());
  anno_panel panel (.ref_clk(ref_clk), .press(press), .levels(levels),
    .reset_key(reset_key), .multifunction_inputs(mfi));

  always #4 ref_clk = ~ref_clk;
  // Random trip requests; hang guard
  always @(posedge ref_clk) begin
    fault_trip <= 1'($random(seed));
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  // Oldest note against each completed read
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata & msk_q.pop_front()}, exp_q.pop_front());
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Leading edge keeps a new setup off the previous release
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e,
    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic end_sim;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    wt(8);
    rst <= 1'b0;
    // Reset values, a hole, read-only targets
    for (int i = 0; i < 5; i++)
      rd(8'(4 * i), (i == 1) ? 33'h1CC : 33'h0, all_m);
    rd(8'h1C, 33'h1_0000_0000, all_m);
    bus(1'b1, 8'h18, all_m);
    bus(1'b1, 8'h14, 32'h0);
    rd(8'h14, 33'h12C, all_m);
    foreach (tv[i]) begin
      bus(1'b1, 8'h00, {16'h0, tv[i][0]});
      bus(1'b1, 8'h04, {16'h0, tv[i][1]});
      bus(1'b1, 8'h08, {16'h0, tv[i][2]});
      bus_voltage <= tv[i][3];
      wt(4);
      rd(8'h18, {17'h0, tv[i][4]}, st_m);
    end
    // Duplicate and out-of-range input functions
    bus_voltage <= 16'h012C;
    run_cmd <= 1'b1;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h0C, 32'h0505);
    wt(4);
    rd(8'h18, 33'h1018, st_m);
    check(33'(run_accept), 33'h0);
    bus(1'b1, 8'h0C, 32'h40);
    wt(4);
    rd(8'h18, 33'h1128, st_m);
    bus(1'b1, 8'h0C, 32'h0);
    wt(4);
    check(33'(run_accept), 33'h1);
    // Each terminal as the overheat input
    for (int i = 0; i < 8; i++) begin
      fn = 32'h20 << (8 * (i % 4));
      bus(1'b1, 8'h0C, (i < 4) ? fn : 32'h0);
      bus(1'b1, 8'h10, (i < 4) ? 32'h0 : fn);
      levels <= ~(8'h01 << i);
      wt(4);
      rd(8'h18, 33'h0, st_m);
      levels <= 8'h01 << i;
      wt(4);
      rd(8'h18, 33'h0304, st_m);
    end
    levels <= 8'h00;
    bus(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 8; i++) begin
      bus_voltage <= 16'h017C + 16'($unsigned($random(seed)) % 441);
      run_cmd <= 1'($random(seed));
      wt(4);
      rd(8'h18, 33'h0, st_m);
      rd(8'h14, {17'h0, bus_voltage}, all_m);
    end
    // Key blanks, code returns, then clears
    bus(1'b1, 8'h00, 32'h0);
    bus_voltage <= 16'h01F4;
    wt(4);
    rd(8'h18, 33'h0101, st_m);
    press <= 1'b1;
    wt(1);
    press <= 1'b0;
    wt(3);
    rd(8'h18, 33'h0001, st_m);
    wt(30);
    rd(8'h18, 33'h0101, st_m);
    bus_voltage <= 16'h012C;
    wt(4);
    rd(8'h18, 33'h0, st_m);
    drive_running <= 1'b1;
    precharge_on <= 1'b0;
    run_cmd <= 1'b1;
    wt(4);
    rd(8'h18, 33'h0202, st_m);
    check(33'(run_accept), 33'h1);
    end_sim();
  end
endmodule
